// file: src/acc_pkg.sv
package acc_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned OSC_HZ = 1_000_000;
    localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int unsigned MOD_DIV = 4;
    localparam int unsigned MOD_HZ = OSC_HZ / MOD_DIV;
    localparam int unsigned DRDY_LEAD_US = 8;
    localparam int unsigned DRDY_LEAD_TICKS =
        (DRDY_LEAD_US * MOD_HZ) / 1_000_000;

    localparam int unsigned WORD_W = 16;
    localparam int unsigned TEMP_W = 14;
    localparam int unsigned RANGE_COUNT = 6;

    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_CONV = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_SPI_RX = 8'h0c;

    localparam logic [15:0] CFG_RESET = 16'h0580;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h8ff0;

    localparam logic [15:0] CODE_MAX = 16'h7fff;
    localparam logic [15:0] CODE_MIN = 16'h8000;

    localparam logic [12:0] FSR_MV [RANGE_COUNT] = '{
        13'h1800, 13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100
    };
    localparam logic [6:0] LSB_NUM = 7'h7d;
    localparam int unsigned LSB_SHIFT = 8;

    localparam int unsigned PIN_CS = 0;
    localparam int unsigned PIN_SCK = 1;
    localparam int unsigned PIN_DIN = 2;
    localparam int unsigned PIN_COUNT = 3;

    typedef struct packed {
        logic oneShot;
        logic [2:0] rsvdHigh;
        logic [2:0] fsrSelect;
        logic mode;
        logic [2:0] dataRate;
        logic tempSensorSelect;
        logic [3:0] rsvdLow;
    } acc_cfg_t;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01,
        ACC_LOAD = 2'b11
    } acc_state_t;

    typedef struct packed {
        logic [11:0] lsbStep;
        logic [2:0] rangeIdx;
        logic [1:0] state;
        logic spiActive;
        logic newData;
        logic busy;
    } acc_status_t;

endpackage

// file: src/acc_conversion_control.sv
// How it works
// [RULE1] modulator clock is the 1 MHz oscillator tick divided by four
// [RULE2] three-bit range field picks one of six full-scale ranges
// [RULE3] code step equals selected range over 2^16, reported in status
// [RULE4] timing comes from an internal oscillator tick, no external clock
// [RULE5] data rate follows oscillator ticks, so drift scales timing
// [RULE6] temperature select bit routes the sensor instead of inputs
// [RULE7] temperature result sits left aligned in the 16-bit word
// [RULE8] one temperature step is 0.03125 degrees, passed unchanged
// [RULE9] conversion word shifts out most significant bit first
// [RULE10] reset returns every configuration bit to its default
// [RULE11] after reset the converter is powered down and idle
// [RULE12] mode bit one means single shot, resting powered down
// [RULE13] registers stay readable and writable while powered down
// [RULE14] trigger write while idle powers up, clears bit, converts once
// [RULE15] single shot returns to power down once result is ready
// [RULE16] trigger write during a conversion is dropped, never queued
// [RULE17] mode bit zero selects continuous conversion
// [RULE18] continuous mode loads each result and restarts at once
// [RULE19] mode bit one or reset leaves continuous mode
// [RULE20] host may pace single shots at its own period
// [RULE21] serial interface carries reads and control, select may be tied low; here words shifted in on DIN only land in spiRx_r and change no configuration
// [RULE22] results are two's complement, clipped at 7fff and 8000
// [RULE23] ready pin goes low when a new result is available
// [RULE24] conversion length is a parameter count of modulator ticks
// [RULE25] range code to range mapping is a lookup parameter
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module acc_conversion_control #(
    parameter int unsigned FILTER_W = 20,
    parameter int unsigned CONV_TICKS [8] = '{
        31250, 15625, 7812, 3906, 1953, 1000, 526, 290
    },
    parameter logic [2:0] RANGE_OF_CODE [8] = '{
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5
    }
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic chipSelect_b,
    input wire logic serialClk,
    input wire logic serialDataIn,
    output logic dataOutReadyPin,
    output logic dataOutReadyOe,
    input wire logic signed [FILTER_W-1:0] filterResult,
    input wire logic [acc_pkg::TEMP_W-1:0] tempResult,
    output logic convStart,
    output logic modulatorClkEn,
    output logic analogPowerUp,
    output logic [2:0] rangeIndex,
    output logic tempSensorSelect
);

    localparam int unsigned OSC_CW = $clog2(acc_pkg::OSC_DIV);
    localparam int unsigned MOD_CW = $clog2(acc_pkg::MOD_DIV);
    localparam int unsigned W = acc_pkg::WORD_W;
    localparam int unsigned PIN_W = acc_pkg::PIN_COUNT;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addrHit(input logic [7:0] a,
                                     input logic [7:0] off);
        addrHit = (a == off);
    endfunction

    function automatic logic [15:0] convTicks(input logic [2:0] rate);
        convTicks = 16'(CONV_TICKS[rate]); // [RULE24]
    endfunction

    // saturate the wide filter word to the 16-bit code space
    function automatic logic [15:0] clipCode(
        input logic signed [FILTER_W-1:0] v);
        logic signed [FILTER_W-1:0] hi;
        logic signed [FILTER_W-1:0] lo;
        hi = FILTER_W'($signed(acc_pkg::CODE_MAX));
        lo = FILTER_W'($signed(acc_pkg::CODE_MIN));
        if (v > hi) begin
            clipCode = acc_pkg::CODE_MAX; // [RULE22]
        end else if (v < lo) begin
            clipCode = acc_pkg::CODE_MIN; // [RULE22]
        end else begin
            clipCode = v[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    acc_pkg::acc_cfg_t cfg_r;
    acc_pkg::acc_state_t state_r;
    acc_pkg::acc_status_t status;
    logic [OSC_CW-1:0] oscCnt_r;
    logic oscTick_r;
    logic [MOD_CW-1:0] modCnt_r;
    logic [15:0] tickCnt_r;
    logic [15:0] convWord_r;
    logic newData_r;
    logic convDone;
    logic leadDrop;
    logic wbAccess;
    logic cfgWrite;
    logic convRead;
    logic [15:0] cfgWord;
    logic [15:0] cfg_nxt;
    logic [2:0] rangeIdx;
    logic [PIN_W-1:0] pinIn;
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic [PIN_W-1:0] sync3_r;
    logic [PIN_W-1:0] pinF_r;
    logic [PIN_W-1:0] pinPrev_r;
    logic sclkRise;
    logic sclkFall;
    logic csHigh;
    logic spiActive_r;
    logic retrieveStart;
    logic [15:0] txShift_r;
    logic [15:0] rxShift_r;
    logic [3:0] rxCnt_r;
    logic [15:0] spiRx_r;
    logic [31:0] readData;

    ////////////////////////////////////////////////////////////////////
    // oscillator tick and modulator clock

    // the 125 MHz clock stands in for the on-chip oscillator
    always_ff @(posedge clk) begin // [RULE4]
        if (!rst_b) begin
            oscCnt_r <= '0;
            oscTick_r <= 1'b0;
        end else if (oscCnt_r == OSC_CW'(acc_pkg::OSC_DIV - 1)) begin
            oscCnt_r <= '0;
            oscTick_r <= 1'b1;
        end else begin
            oscCnt_r <= oscCnt_r + 1'b1;
            oscTick_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin // [RULE1]
        if (!rst_b) begin
            modCnt_r <= '0;
            modulatorClkEn <= 1'b0;
        end else if (oscTick_r) begin
            modCnt_r <= modCnt_r + 1'b1;
            modulatorClkEn <= (modCnt_r == MOD_CW'(acc_pkg::MOD_DIV - 1));
        end else begin
            modulatorClkEn <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register bus

    assign wbAccess = cyc_i & stb_i & ~ack_o;
    assign cfgWrite = wbAccess & we_i & addrHit(adr_i, acc_pkg::ADDR_CONFIG);
    assign convRead = wbAccess & ~we_i & addrHit(adr_i, acc_pkg::ADDR_CONV);
    assign cfgWord = cfg_r;

    // byte lanes merged, reserved bits forced to zero
    always_comb begin
        cfg_nxt = cfgWord;
        if (sel_i[0]) begin
            cfg_nxt[7:0] = dat_i[7:0];
        end
        if (sel_i[1]) begin
            cfg_nxt[15:8] = dat_i[15:8];
        end
        cfg_nxt = cfg_nxt & acc_pkg::CFG_WRITE_MASK;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wbAccess; // [RULE13]
        end
    end

    always_comb begin
        readData = '0;
        if (addrHit(adr_i, acc_pkg::ADDR_CONFIG)) begin
            readData = {16'h0000, cfgWord};
        end else if (addrHit(adr_i, acc_pkg::ADDR_CONV)) begin
            readData = {16'h0000, convWord_r};
        end else if (addrHit(adr_i, acc_pkg::ADDR_STATUS)) begin
            readData = {12'h000, status};
        end else if (addrHit(adr_i, acc_pkg::ADDR_SPI_RX)) begin
            readData = {16'h0000, spiRx_r};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dat_o <= '0;
        end else if (wbAccess & ~we_i) begin
            dat_o <= readData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_r <= acc_pkg::CFG_RESET; // [RULE10] [RULE19]
        end else begin
            if (cfgWrite) begin
                cfg_r <= cfg_nxt;
                // trigger only lands while idle, so it never queues
                cfg_r.oneShot <= cfg_nxt[15] &
                    (state_r == acc_pkg::ACC_IDLE); // [RULE16]
            end else if (state_r == acc_pkg::ACC_IDLE &&
                         cfg_r.oneShot) begin
                cfg_r.oneShot <= 1'b0; // [RULE14]
            end
        end
    end

    assign rangeIdx = RANGE_OF_CODE[cfg_r.fsrSelect]; // [RULE25]

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rangeIndex <= RANGE_OF_CODE[acc_pkg::CFG_RESET[11:9]];
            tempSensorSelect <= 1'b0;
        end else begin
            rangeIndex <= rangeIdx; // [RULE2]
            tempSensorSelect <= cfg_r.tempSensorSelect; // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion sequencing

    assign convDone = (state_r == acc_pkg::ACC_CONV) & modulatorClkEn &
        (tickCnt_r == convTicks(cfg_r.dataRate) - 16'h0001); // [RULE5]

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= acc_pkg::ACC_IDLE; // [RULE11]
            convStart <= 1'b0;
        end else begin
            convStart <= 1'b0;
            unique case (state_r)
                acc_pkg::ACC_IDLE: begin
                    if (!cfg_r.mode || cfg_r.oneShot) begin // [RULE17]
                        state_r <= acc_pkg::ACC_CONV;
                        convStart <= 1'b1; // [RULE14]
                    end
                end
                acc_pkg::ACC_CONV: begin
                    if (convDone) begin
                        state_r <= acc_pkg::ACC_LOAD;
                    end
                end
                acc_pkg::ACC_LOAD: begin
                    if (!cfg_r.mode) begin
                        state_r <= acc_pkg::ACC_CONV; // [RULE18]
                        convStart <= 1'b1;
                    end else begin
                        state_r <= acc_pkg::ACC_IDLE; // [RULE12] [RULE15]
                    end
                end
                default: begin
                    state_r <= acc_pkg::ACC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || state_r != acc_pkg::ACC_CONV) begin
            tickCnt_r <= '0;
        end else if (modulatorClkEn) begin
            tickCnt_r <= tickCnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            analogPowerUp <= 1'b0;
        end else begin
            analogPowerUp <= (state_r != acc_pkg::ACC_IDLE); // [RULE12]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            convWord_r <= '0;
        end else if (state_r == acc_pkg::ACC_LOAD) begin
            if (cfg_r.tempSensorSelect) begin
                // sensor lsb is 0.03125 C, kept as delivered
                convWord_r <= {tempResult, 2'b00}; // [RULE7] [RULE8]
            end else begin
                convWord_r <= clipCode(filterResult); // [RULE22]
            end
        end
    end

    // in continuous mode unread data is withdrawn just before the next result lands
    assign leadDrop = ~cfg_r.mode & (state_r == acc_pkg::ACC_CONV) &
        (convTicks(cfg_r.dataRate) - tickCnt_r <=
         16'(acc_pkg::DRDY_LEAD_TICKS));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            newData_r <= 1'b0;
        end else if (state_r == acc_pkg::ACC_LOAD) begin
            newData_r <= 1'b1; // set wins over any retrieval
        end else if (retrieveStart || convRead || leadDrop) begin
            newData_r <= 1'b0;
        end
    end

    // step in 1/16 uV: range mV * 125 / 256
    always_comb begin
        status = '0;
        status.lsbStep = 12'((20'(acc_pkg::FSR_MV[rangeIdx]) *
            20'(acc_pkg::LSB_NUM)) >> acc_pkg::LSB_SHIFT); // [RULE3]
        status.rangeIdx = rangeIdx;
        status.state = state_r;
        status.spiActive = spiActive_r;
        status.newData = newData_r;
        status.busy = (state_r != acc_pkg::ACC_IDLE);
    end

    ////////////////////////////////////////////////////////////////////
    // serial pins

    assign pinIn[acc_pkg::PIN_CS] = chipSelect_b;
    assign pinIn[acc_pkg::PIN_SCK] = serialClk;
    assign pinIn[acc_pkg::PIN_DIN] = serialDataIn;

    // three stages; a level counts once the last two agree
    for (genvar i = 0; i < PIN_W; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                // idle levels, so no false select follows reset
                sync1_r[i] <= (i == acc_pkg::PIN_CS);
                sync2_r[i] <= (i == acc_pkg::PIN_CS);
                sync3_r[i] <= (i == acc_pkg::PIN_CS);
                pinF_r[i] <= (i == acc_pkg::PIN_CS);
                pinPrev_r[i] <= (i == acc_pkg::PIN_CS);
            end else begin
                sync1_r[i] <= pinIn[i];
                sync2_r[i] <= sync1_r[i];
                sync3_r[i] <= sync2_r[i];
                if (sync2_r[i] == sync3_r[i]) begin
                    pinF_r[i] <= sync3_r[i];
                end
                pinPrev_r[i] <= pinF_r[i];
            end
        end
    end

    assign csHigh = pinF_r[acc_pkg::PIN_CS];
    assign sclkRise = ~pinPrev_r[acc_pkg::PIN_SCK] &
        pinF_r[acc_pkg::PIN_SCK] & ~csHigh;
    assign sclkFall = pinPrev_r[acc_pkg::PIN_SCK] &
        ~pinF_r[acc_pkg::PIN_SCK] & ~csHigh;
    // with select tied low the first clock edge opens the frame
    assign retrieveStart = sclkRise & ~spiActive_r; // [RULE21]

    always_ff @(posedge clk) begin
        if (!rst_b || csHigh) begin
            spiActive_r <= 1'b0;
            txShift_r <= '0;
            rxShift_r <= '0;
            rxCnt_r <= '0;
        end else begin
            if (retrieveStart) begin
                // result is frozen for the first 16 clocks of the frame
                txShift_r <= {convWord_r[W-2:0], 1'b0}; // [RULE9]
                spiActive_r <= 1'b1;
            end else if (sclkRise) begin
                txShift_r <= {txShift_r[W-2:0], 1'b0}; // [RULE9]
            end
            if (sclkFall) begin
                rxShift_r <= {rxShift_r[W-2:0], pinF_r[acc_pkg::PIN_DIN]};
                rxCnt_r <= rxCnt_r + 4'h1;
                if (rxCnt_r == 4'hf) begin
                    // second half of a long frame echoes the config
                    txShift_r <= cfgWord;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            spiRx_r <= '0;
        end else if (sclkFall && rxCnt_r == 4'hf && !csHigh) begin
            spiRx_r <= {rxShift_r[W-2:0], pinF_r[acc_pkg::PIN_DIN]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || csHigh) begin
            dataOutReadyPin <= 1'b1;
            dataOutReadyOe <= 1'b0;
        end else begin
            dataOutReadyOe <= 1'b1;
            if (retrieveStart) begin
                dataOutReadyPin <= convWord_r[W-1]; // [RULE9]
            end else if (sclkRise) begin
                dataOutReadyPin <= txShift_r[W-1];
            end else if (!spiActive_r) begin
                dataOutReadyPin <= ~newData_r; // [RULE23]
            end
        end
    end

endmodule

// file: sim/acc_ctrl_monitor.sv
`timescale 1ns/100ps
module acc_ctrl_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic convStart,
    input wire logic modulatorClkEn,
    input wire logic analogPowerUp,
    input wire logic [2:0] rangeIndex,
    input wire logic tempSensorSelect,
    input wire logic dataOutReadyPin,
    input wire logic dataOutReadyOe
);
    logic [9:0] tickGap_r;
    logic seenTick_r;
    logic cfgWr;
    assign cfgWr = cyc_i && stb_i && we_i && ack_o
        && adr_i == acc_pkg::ADDR_CONFIG;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
////////////////////////////////////////////////////////////////////////
    // first tick after reset has no reference, so it is not judged
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tickGap_r <= 10'h000;
            seenTick_r <= 1'b0;
        end else if (modulatorClkEn) begin
            tickGap_r <= 10'h000;
            seenTick_r <= 1'b1;
        end else begin
            tickGap_r <= tickGap_r + 10'h001;
        end
    end
////////////////////////////////////////////////////////////////////////
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not acknowledged");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_tick_period: assert property (
        modulatorClkEn && seenTick_r |-> tickGap_r == 10'h1f3)
        else $error("modulator tick period wrong");
    a_reset_idle: assert property (
        $rose(rst_b) |-> !analogPowerUp && !convStart)
        else $error("converter active after reset");
    a_start_power: assert property (
        convStart |-> ##[1:2] analogPowerUp)
        else $error("no power up after start");
    a_start_spacing: assert property (
        convStart |=> !convStart [*8])
        else $error("conversion restarted early");
    a_range_bound: assert property (rangeIndex < 3'h6)
        else $error("range index beyond six ranges");
    a_range_write: assert property (
        cfgWr && sel_i[1] |=> rangeIndex ==
        ($past(dat_i[11:9]) > 3'h5 ? 3'h5 : $past(dat_i[11:9])))
        else $error("range index not following field");
    a_temp_write: assert property (
        cfgWr && sel_i[0] |=> tempSensorSelect == $past(dat_i[4]))
        else $error("temperature select not following bit");
    a_shot_go: assert property (
        cfgWr && sel_i[1] && dat_i[15] && !analogPowerUp && !convStart
        |-> ##[1:3] convStart)
        else $error("single shot did not start");
    c_start: cover property (convStart);
    c_read: cover property (ack_o && !we_i);
    c_ready: cover property (dataOutReadyOe && !dataOutReadyPin);
endmodule

// file: sim/acc_spi_host.sv
`timescale 1ns/100ps
module acc_spi_host (
    input wire logic clk,
    input wire logic doutPin,
    input wire logic doutOe,
    output logic csOut_b,
    output logic sclkOut,
    output logic dinOut
);
    logic wireLvl;
    // released pin rests at its pull-up level
    assign wireLvl = doutOe ? doutPin : 1'b1;
    initial begin
        csOut_b = 1'b1;
        sclkOut = 1'b0;
        dinOut = 1'b0;
    end
    // slow levels: pins pass a synchroniser inside the block
    task automatic frame(input logic [15:0] tx, output logic rdy,
                         output logic [15:0] rx);
        @(posedge clk);
        csOut_b <= 1'b0;
        repeat (16) @(posedge clk);
        rdy = wireLvl;
        for (int i = 15; i >= 0; i--) begin
            sclkOut <= 1'b1;
            dinOut <= tx[i];
            repeat (16) @(posedge clk);
            rx[i] = wireLvl;
            sclkOut <= 1'b0;
            repeat (16) @(posedge clk);
        end
        csOut_b <= 1'b1;
        dinOut <= ~dinOut;
    endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR;
    logic ack, pin, oe, csB, sclk, din, start, modEn, pwr, tsel, rdy;
    logic [2:0] ridx;
    logic signed [19:0] filt = 20'sh0;
    logic [13:0] temp = 14'h0;
    logic [15:0] rx, txw, e16;
    logic [31:0] expQ [$];
    logic [11:0] lsbTab [6] = '{12'hbb8, 12'h7d0, 12'h3e8, 12'h1f4,
                                12'h0fa, 12'h07d};
    int errorCnt = 0;
    int totalChecks = 0;
    int starts = 0;
    int cycles = 0;
    always #4 clk = ~clk;
////////////////////////////////////////////////////////////////////////
    acc_conversion_control #(
        .CONV_TICKS('{4, 4, 4, 4, 4, 4, 4, 4})
    ) acc_conversion_control_i (
        .clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
        .ack_o(ack), .chipSelect_b(csB), .serialClk(sclk),
        .serialDataIn(din), .dataOutReadyPin(pin),
        .dataOutReadyOe(oe), .filterResult(filt), .tempResult(temp),
        .convStart(start), .modulatorClkEn(modEn),
        .analogPowerUp(pwr), .rangeIndex(ridx), .tempSensorSelect(tsel)
    );
    acc_spi_host acc_spi_host_i (
        .clk(clk), .doutPin(pin), .doutOe(oe), .csOut_b(csB),
        .sclkOut(sclk), .dinOut(din)
    );
////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] g,
                       input logic [31:0] e);
        totalChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        sel <= 4'h3;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // second write lands mid-conversion and must be dropped
    task automatic shot(input logic [15:0] cfg);
        int s0;
        s0 = starts;
        wb(1'b1, acc_pkg::ADDR_CONFIG, {16'h0, cfg});
        wb(1'b1, acc_pkg::ADDR_CONFIG, {16'h0, cfg});
        while (pwr !== 1'b1) @(posedge clk);
        while (pwr !== 1'b0) @(posedge clk);
        repeat (2) @(posedge clk);
        chk("starts", 32'(starts - s0), 32'h1);
        rd(acc_pkg::ADDR_CONFIG, {16'h0, cfg & acc_pkg::CFG_WRITE_MASK
            & 16'h7fff});
    endtask
////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (start === 1'b1) starts++;
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
            chk("bus read", datR, expQ.pop_front());
        if (cycles == 40000) begin
            errorCnt++;
            finalReport();
        end
    end
    initial begin
        logic [2:0] r;
        logic [19:0] v;
        int n;
        void'($urandom(2));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("power up", {31'h0, pwr}, 32'h0);
        chk("range index", {29'h0, ridx}, 32'h2);
        rd(acc_pkg::ADDR_CONFIG, {16'h0, acc_pkg::CFG_RESET});
        wb(1'b1, 8'h10, 32'hffff);
        rd(8'h10, 32'h0);
        repeat (600) @(posedge clk);
        chk("idle starts", 32'(starts), 32'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            r = c > 5 ? 3'h5 : 3'(c);
            wb(1'b1, acc_pkg::ADDR_CONFIG, 32'h0100 | (c << 9));
            rd(acc_pkg::ADDR_STATUS, {12'h0, lsbTab[r], r, 5'h0});
            chk("range index", {29'h0, ridx}, {29'h0, r});
        end
        $display("test range done");
        temp <= 14'($urandom);
        txw = 16'($urandom);
        shot(16'h8110);
        e16 = {temp, 2'b00};
        chk("temp select", {31'h0, tsel}, 32'h1);
        acc_spi_host_i.frame(txw, rdy, rx);
        chk("ready pin", {31'h0, rdy}, 32'h0);
        chk("serial word", 32'(rx), 32'(e16));
        rd(acc_pkg::ADDR_SPI_RX, {16'h0, txw});
        rd(acc_pkg::ADDR_CONV, {16'h0, e16});
        $display("test temperature done");
        for (int k = 0; k < 2; k++) begin
            v = 20'h08000 + 20'($urandom % 32'h77fff);
            filt <= k ? ~v + 20'h1 : v;
            shot(16'h8100);
            rd(acc_pkg::ADDR_CONV, k ? 32'h8000 : 32'h7fff);
        end
        $display("test clipping done");
        filt <= 20'sh80000;
        wb(1'b1, acc_pkg::ADDR_CONFIG, 32'h0000);
        n = starts;
        while (starts < n + 3) @(posedge clk);
        wb(1'b1, acc_pkg::ADDR_CONFIG, 32'h0100);
        while (pwr !== 1'b0) @(posedge clk);
        n = starts;
        repeat (2500) @(posedge clk);
        chk("starts", 32'(starts - n), 32'h0);
        rd(acc_pkg::ADDR_CONV, 32'h8000);
        $display("test continuous done");
        finalReport();
    end
endmodule
bind acc_conversion_control acc_ctrl_monitor acc_ctrl_monitor_i (
    .clk(clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .convStart(convStart), .modulatorClkEn(modulatorClkEn),
    .analogPowerUp(analogPowerUp), .rangeIndex(rangeIndex),
    .tempSensorSelect(tempSensorSelect),
    .dataOutReadyPin(dataOutReadyPin), .dataOutReadyOe(dataOutReadyOe)
);
